// file: coast_pkg.sv
// Operation
// [RULE1] a terminal whose function code is 11 acts as the coast stop input
// [RULE2] while coast stop is held the output stays off and the motor coasts
// [RULE3] after coast stop release, restart follows the retry wait of 0.3 to 100 s
// [RULE4] no automatic restart when the configured run source is the panel (02); code goes idle, and a held run_cmd_panel restarts from zero
// [RULE5] restart mode 00 zero frequency, 01 matched frequency, 02 active matching
// [RULE6] matched mode starts from zero when motor frequency is below threshold
// [RULE7] matched mode waits, measures coasting frequency, resumes there without stopping
// [RULE8] matched mode falls back to zero at half base frequency or fast decay
// [RULE9] zero mode restarts from zero at once, ignoring the retry wait
// [RULE10] active matching starts at shutoff, maximum or newly set frequency
// [RULE11] active matching decelerates at scan rate, current held, then reaccelerates
// [RULE12] scan start current is held within 0.20 to 1.50 times rated current
// [RULE13] code 31 input forces frequency and run commands from the panel
// [RULE14] code 51 input forces frequency and run commands from the terminals
// [RULE15] a command source change while running cancels the run and stops output
// [RULE16] the operator withdraws every run command before issuing a new one; code only waits for the selected source's run command to be low
// [RULE17] retry wait starts on release and restarts if coast stop returns
package coast_pkg;
  // ****************************************
  // terminal function codes
  // ****************************************
  localparam logic [7:0] FN_COAST_STOP = 8'h0b;
  localparam logic [7:0] FN_FORCE_PANEL = 8'h1f;
  localparam logic [7:0] FN_FORCE_TERM = 8'h33;
  // ****************************************
  // source, mode and select codes
  // ****************************************
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  localparam logic [1:0] SRC_PANEL = 2'h2;
  localparam logic [1:0] MODE_ZERO = 2'h0;
  localparam logic [1:0] MODE_MATCH = 2'h1;
  localparam logic [1:0] MODE_ACTIVE = 2'h2;
  localparam logic [1:0] SEL_SHUTOFF = 2'h0;
  localparam logic [1:0] SEL_MAX = 2'h1;
  localparam logic [1:0] SEL_NEW = 2'h2;
  // ****************************************
  // setting ranges (0.1 s, 0.01 Hz, 0.01 s, 0.01 x rated)
  // ****************************************
  localparam logic [9:0] RETRY_MIN = 10'h003;
  localparam logic [9:0] RETRY_MAX = 10'h3e8;
  localparam logic [15:0] THR_MAX = 16'h9c40;
  localparam logic [11:0] SCAN_TC_MIN = 12'h00a;
  localparam logic [11:0] SCAN_TC_MAX = 12'hbb8;
  localparam logic [7:0] SCAN_CUR_MIN = 8'h14;
  localparam logic [7:0] SCAN_CUR_MAX = 8'h96;
  localparam logic [7:0] CUR_FREE = 8'hff;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_NS = 5;
  localparam int RETRY_UNIT_MS = 100;
  localparam int RETRY_UNIT_CYC = CLK_HZ / 1000 * RETRY_UNIT_MS;
  localparam int STEP_NS = 1000;
  localparam int STEP_CYC = STEP_NS / CLK_NS;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RUN = 6'h02,
    S_COAST = 6'h04,
    S_WAIT = 6'h08,
    S_SCAN = 6'h10,
    S_ACCEL = 6'h20
  } state_t;
endpackage

// file: free_run_stop_restart_control.sv
`timescale 1ns/1ps
module free_run_stop_restart_control #(
  parameter int NTERM = 8,
  parameter int RETRY_UNIT_CYC = coast_pkg::RETRY_UNIT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [NTERM-1:0] terminal_in,
  input wire logic [NTERM*8-1:0] input_terminal_function_select,
  input wire logic [1:0] frequency_source_select,
  input wire logic [1:0] run_source_select,
  input wire logic [1:0] coast_restart_mode,
  input wire logic [1:0] scan_restart_freq_select,
  input wire logic [9:0] retry_wait_time,
  input wire logic [15:0] restart_freq_threshold,
  input wire logic [7:0] scan_start_current,
  input wire logic [11:0] scan_time_constant,
  input wire logic run_cmd_panel,
  input wire logic run_cmd_terminal,
  input wire logic run_cmd_config,
  input wire logic [15:0] freq_cmd_panel,
  input wire logic [15:0] freq_cmd_terminal,
  input wire logic [15:0] freq_cmd_config,
  input wire logic [15:0] max_freq,
  input wire logic [15:0] base_freq,
  input wire logic [15:0] motor_freq,
  input wire logic voltage_decay_fast,
  input wire logic voltage_match,
  output logic output_enable,
  output logic [15:0] output_freq,
  output logic [7:0] current_limit,
  output logic run_cancel,
  output logic [5:0] state_code
);
  localparam int TW = $clog2(RETRY_UNIT_CYC + 1);

  typedef struct packed {
    logic [NTERM-1:0] s1;
    logic [NTERM-1:0] s2;
    logic [NTERM-1:0] s3;
    logic [NTERM-1:0] term;
    coast_pkg::state_t st;
    logic [3:0] src;
    logic lock;
    logic drive;
    logic cancel;
    logic [TW-1:0] tick_cnt;
    logic [9:0] wait_cnt;
    logic [7:0] us_cnt;
    logic [11:0] step_cnt;
    logic [15:0] freq;
    logic [15:0] target;
    logic [15:0] shut_freq;
    logic [7:0] cur_lim;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    st: coast_pkg::S_IDLE,
    cur_lim: coast_pkg::CUR_FREE,
    default: '0
  };

  ctl_t q;
  ctl_t d;

  // ****************************************
  // terminal decode and source selection
  // ****************************************
  logic [NTERM-1:0] is_coast;
  logic [NTERM-1:0] is_panel;
  logic [NTERM-1:0] is_term;
  logic coast_now;
  logic force_panel_control;
  logic force_terminal_control;

  // a terminal may carry any function; several with one code simply OR
  always_comb begin
    for (int i = 0; i < NTERM; i++) begin
      is_coast[i] = input_terminal_function_select[i*8 +: 8]
        == coast_pkg::FN_COAST_STOP; // RULE1
      is_panel[i] = input_terminal_function_select[i*8 +: 8]
        == coast_pkg::FN_FORCE_PANEL;
      is_term[i] = input_terminal_function_select[i*8 +: 8]
        == coast_pkg::FN_FORCE_TERM;
    end
  end

  assign coast_now = |(q.term & is_coast); // RULE1
  assign force_panel_control = |(q.term & is_panel);
  assign force_terminal_control = |(q.term & is_term);

  logic [1:0] run_src;
  logic [1:0] freq_src;
  logic run_now;
  logic [15:0] freq_now;

  // panel override wins when both override inputs are held
  always_comb begin
    if (force_panel_control) begin
      run_src = coast_pkg::SRC_PANEL; // RULE13
      freq_src = coast_pkg::SRC_PANEL; // RULE13
    end else if (force_terminal_control) begin
      run_src = coast_pkg::SRC_TERMINAL; // RULE14
      freq_src = coast_pkg::SRC_TERMINAL; // RULE14
    end else begin
      run_src = run_source_select;
      freq_src = frequency_source_select;
    end
    case (run_src)
      coast_pkg::SRC_PANEL: run_now = run_cmd_panel;
      coast_pkg::SRC_TERMINAL: run_now = run_cmd_terminal;
      default: run_now = run_cmd_config;
    endcase
    case (freq_src)
      coast_pkg::SRC_PANEL: freq_now = freq_cmd_panel;
      coast_pkg::SRC_TERMINAL: freq_now = freq_cmd_terminal;
      default: freq_now = freq_cmd_config;
    endcase
  end

  // ****************************************
  // clamped settings and timers
  // ****************************************
  logic [9:0] retry_lim;
  logic [15:0] thr_lim;
  logic [7:0] scan_cur;
  logic [11:0] scan_tc;
  logic tick;
  logic us_tick;
  logic wait_done;
  logic freq_low;
  logic src_change;

  // out-of-range settings are pulled to the nearest legal value
  assign retry_lim = (retry_wait_time < coast_pkg::RETRY_MIN) ? coast_pkg::RETRY_MIN :
    (retry_wait_time > coast_pkg::RETRY_MAX) ? coast_pkg::RETRY_MAX : retry_wait_time;
  assign thr_lim = (restart_freq_threshold > coast_pkg::THR_MAX) ?
    coast_pkg::THR_MAX : restart_freq_threshold;
  assign scan_cur = (scan_start_current < coast_pkg::SCAN_CUR_MIN) ? coast_pkg::SCAN_CUR_MIN :
    (scan_start_current > coast_pkg::SCAN_CUR_MAX) ? coast_pkg::SCAN_CUR_MAX :
    scan_start_current; // RULE12
  assign scan_tc = (scan_time_constant < coast_pkg::SCAN_TC_MIN) ? coast_pkg::SCAN_TC_MIN :
    (scan_time_constant > coast_pkg::SCAN_TC_MAX) ? coast_pkg::SCAN_TC_MAX :
    scan_time_constant;

  assign tick = q.tick_cnt == TW'(RETRY_UNIT_CYC - 1);
  assign us_tick = q.us_cnt == 8'(coast_pkg::STEP_CYC - 1);
  assign wait_done = q.wait_cnt >= retry_lim; // RULE3
  // below threshold, or at most half base, or decaying: start from zero
  assign freq_low = (motor_freq < thr_lim) || voltage_decay_fast ||
    ({motor_freq, 1'b0} <= {1'b0, base_freq}); // RULE6 RULE8
  assign src_change = {run_src, freq_src} != q.src;

  // ****************************************
  // restart sequencer
  // ****************************************
  always_comb begin
    d = q;
    d.s1 = terminal_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.term = q.s3;
    end
    d.src = {run_src, freq_src};
    d.cancel = 1'b0;
    d.us_cnt = us_tick ? 8'h00 : q.us_cnt + 8'h01;
    d.tick_cnt = tick ? '0 : q.tick_cnt + TW'(1);
    // a cancelled run stays locked until the run command of the newly selected source is low
    if (!run_now) begin
      d.lock = 1'b0;
    end
    case (q.st)
      coast_pkg::S_IDLE: begin
        if (run_now && !q.lock && !coast_now) begin
          d.freq = 16'h0000;
          d.target = freq_now;
          d.st = coast_pkg::S_ACCEL;
        end
      end
      coast_pkg::S_RUN: begin
        d.freq = freq_now;
        if (coast_now) begin
          d.shut_freq = q.freq;
          d.st = coast_pkg::S_COAST; // RULE2
        end else if (!run_now) begin
          d.st = coast_pkg::S_IDLE;
        end
      end
      coast_pkg::S_COAST: begin
        if (!run_now) begin
          d.st = coast_pkg::S_IDLE;
        end else if (!coast_now) begin
          if (run_source_select == coast_pkg::SRC_PANEL) begin
            d.st = coast_pkg::S_IDLE; // RULE4
          end else if (coast_restart_mode == coast_pkg::MODE_ZERO) begin
            d.freq = 16'h0000; // RULE9
            d.target = freq_now;
            d.st = coast_pkg::S_ACCEL; // RULE5
          end else begin
            d.wait_cnt = 10'h000; // RULE17
            d.tick_cnt = '0; // RULE17
            d.st = coast_pkg::S_WAIT; // RULE3
          end
        end
      end
      coast_pkg::S_WAIT: begin
        if (coast_now) begin
          d.st = coast_pkg::S_COAST; // RULE17
        end else if (!run_now) begin
          d.st = coast_pkg::S_IDLE;
        end else if (wait_done) begin
          if (coast_restart_mode == coast_pkg::MODE_MATCH) begin
            d.freq = freq_low ? 16'h0000 : motor_freq; // RULE7
            d.target = freq_now;
            d.st = coast_pkg::S_ACCEL;
          end else begin
            case (scan_restart_freq_select)
              coast_pkg::SEL_MAX: d.freq = max_freq; // RULE10
              coast_pkg::SEL_NEW: d.freq = freq_now; // RULE10
              default: d.freq = q.shut_freq; // RULE10
            endcase
            d.target = q.shut_freq;
            d.step_cnt = 12'h000;
            d.st = coast_pkg::S_SCAN;
          end
        end else if (tick) begin
          d.wait_cnt = q.wait_cnt + 10'h001;
        end
      end
      coast_pkg::S_SCAN: begin
        if (coast_now) begin
          d.st = coast_pkg::S_COAST;
        end else if (!run_now) begin
          d.st = coast_pkg::S_IDLE;
        end else if (voltage_match || q.freq == 16'h0000) begin
          d.st = coast_pkg::S_ACCEL; // RULE11
        end else if (us_tick) begin
          // one 0.01 Hz step per scan_tc microseconds
          if (q.step_cnt >= scan_tc - 12'h001) begin
            d.step_cnt = 12'h000;
            d.freq = q.freq - 16'h0001; // RULE11
          end else begin
            d.step_cnt = q.step_cnt + 12'h001;
          end
        end
      end
      coast_pkg::S_ACCEL: begin
        if (coast_now) begin
          d.shut_freq = q.target;
          d.st = coast_pkg::S_COAST;
        end else if (!run_now) begin
          d.st = coast_pkg::S_IDLE;
        end else if (q.freq == q.target) begin
          d.st = coast_pkg::S_RUN;
        end else if (us_tick) begin
          d.freq = (q.freq < q.target) ? q.freq + 16'h0001 : q.freq - 16'h0001;
        end
      end
      default: begin
        d.st = coast_pkg::S_IDLE;
      end
    endcase
    // a switch of source aborts whatever sequence is under way
    if (src_change && q.st != coast_pkg::S_IDLE) begin
      d.st = coast_pkg::S_IDLE; // RULE15
      d.lock = 1'b1; // RULE15
      d.cancel = 1'b1;
    end
    d.drive = d.st inside {coast_pkg::S_RUN, coast_pkg::S_SCAN, coast_pkg::S_ACCEL}; // RULE2
    d.cur_lim = (d.st == coast_pkg::S_SCAN) ? scan_cur : coast_pkg::CUR_FREE; // RULE11
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  assign output_enable = q.drive;
  assign output_freq = q.freq;
  assign current_limit = q.cur_lim;
  assign run_cancel = q.cancel;
  assign state_code = q.st;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  coast_entry_a: assert property ( // RULE1
    $rose(q.st == coast_pkg::S_COAST) |-> $past(coast_now))
    else $error("coast entered without coast input");
  coast_off_a: assert property ( // RULE2
    coast_now && q.st != coast_pkg::S_IDLE |=> !q.drive)
    else $error("output driven during coast stop");
  wait_start_a: assert property ( // RULE17
    q.st == coast_pkg::S_COAST && run_now && !coast_now && !src_change &&
    run_source_select != coast_pkg::SRC_PANEL &&
    coast_restart_mode != coast_pkg::MODE_ZERO
    |=> q.st == coast_pkg::S_WAIT && q.wait_cnt == 10'h000 && !q.drive)
    else $error("retry wait not started on release");
  wait_hold_a: assert property ( // RULE3
    q.st == coast_pkg::S_WAIT && !wait_done |=> !q.drive)
    else $error("restart before retry wait elapsed");
  panel_hold_a: assert property ( // RULE4
    q.st == coast_pkg::S_COAST && !coast_now &&
    run_source_select == coast_pkg::SRC_PANEL |=> q.st == coast_pkg::S_IDLE)
    else $error("automatic restart with panel run source");
  zero_mode_a: assert property ( // RULE9
    q.st == coast_pkg::S_COAST && run_now && !coast_now && !src_change &&
    run_source_select != coast_pkg::SRC_PANEL &&
    coast_restart_mode == coast_pkg::MODE_ZERO
    |=> q.st == coast_pkg::S_ACCEL && q.freq == 16'h0000)
    else $error("zero mode did not restart at once from zero");
  low_thresh_a: assert property ( // RULE6
    q.st == coast_pkg::S_WAIT && wait_done && run_now && !coast_now && !src_change &&
    coast_restart_mode == coast_pkg::MODE_MATCH && motor_freq < thr_lim
    |=> q.freq == 16'h0000)
    else $error("matched restart below threshold not from zero");
  scan_cur_a: assert property ( // RULE11
    q.st == coast_pkg::S_SCAN |-> q.cur_lim == $past(scan_cur) && q.drive)
    else $error("scan current not held");
  src_cancel_a: assert property ( // RULE15
    src_change && q.st != coast_pkg::S_IDLE |=> !q.drive && q.cancel ##1 !q.cancel)
    else $error("source change did not cancel run");
  force_panel_a: assert property ( // RULE13
    force_panel_control && q.st == coast_pkg::S_RUN
    |=> q.freq == $past(freq_cmd_panel))
    else $error("panel override not applied");

  matched_restart_c: cover property (
    q.st == coast_pkg::S_WAIT && coast_restart_mode == coast_pkg::MODE_MATCH
    ##1 q.st == coast_pkg::S_ACCEL);
  scan_done_c: cover property (q.st == coast_pkg::S_SCAN ##1 q.st == coast_pkg::S_ACCEL);
  cancel_c: cover property (q.cancel);
  rewait_c: cover property (q.st == coast_pkg::S_WAIT ##1 q.st == coast_pkg::S_COAST);
endmodule

// file: motor_model.sv
`timescale 1ns/1ps
module motor_model #(
  parameter int DECAY_CYC = 100000
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic output_enable,
  input wire logic [15:0] output_freq,
  input wire logic [7:0] current_limit,
  output logic [15:0] motor_freq,
  output logic voltage_match
);
  int decay_cnt;
  // ****************************************
  // shaft speed
  // ****************************************
  // the shaft follows the output stage, except during a scan, where a limited current
  // cannot pull it up; released, it coasts and loses speed slowly
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      motor_freq <= 16'h0000;
      decay_cnt <= 0;
    end else if (output_enable && (current_limit == 8'hff || output_freq <= motor_freq)) begin
      motor_freq <= output_freq;
      decay_cnt <= 0;
    end else if (!output_enable) begin
      decay_cnt <= decay_cnt + 1;
      if (decay_cnt >= DECAY_CYC && motor_freq != 16'h0000) begin
        motor_freq <= motor_freq - 16'h0001;
        decay_cnt <= 0;
      end
    end
  end
  // voltage agrees once the scanned output has come down to the shaft speed
  assign voltage_match = output_enable && current_limit != 8'hff && output_freq <= motor_freq;
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [5:0] st;
    logic en;
    logic fchk;
    logic [15:0] fr;
    logic [7:0] cl;
  } note_t;
  localparam int MAX_CYC = 90000;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] term = 8'h00;
  logic [63:0] fsel = 64'h0;
  logic [1:0] fsrc = 2'h0, rsrc = 2'h0, mode = 2'h0, sel = 2'h0;
  logic [9:0] retry = 10'h003;
  logic [15:0] thr = 16'h0002, fpan = 16'h0003, fterm = 16'h0002, fcfg = 16'h0008;
  logic [15:0] fmax = 16'h000c, base = 16'h000a;
  logic [7:0] scur = 8'h32, exp_cl;
  logic [11:0] stc = 12'h000;
  logic run_p = 1'b0, run_t = 1'b0, run_c = 1'b0, decay = 1'b0;
  logic [15:0] motor, ofreq, start;
  logic vmatch, oen, cancel;
  logic [7:0] climit;
  logic [5:0] state_code, last_st = 6'h01;
  note_t notes[$];
  note_t n;
  int n_mismatch = 0, checks_done = 0, cycles = 0, ci, pi, ti, wc;
  localparam logic [7:0] FF = 8'hff;

  free_run_stop_restart_control #(.NTERM(8), .RETRY_UNIT_CYC(20)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .terminal_in(term),
    .input_terminal_function_select(fsel), .frequency_source_select(fsrc),
    .run_source_select(rsrc), .coast_restart_mode(mode), .scan_restart_freq_select(sel),
    .retry_wait_time(retry), .restart_freq_threshold(thr), .scan_start_current(scur),
    .scan_time_constant(stc), .run_cmd_panel(run_p), .run_cmd_terminal(run_t),
    .run_cmd_config(run_c), .freq_cmd_panel(fpan), .freq_cmd_terminal(fterm),
    .freq_cmd_config(fcfg), .max_freq(fmax), .base_freq(base), .motor_freq(motor),
    .voltage_decay_fast(decay), .voltage_match(vmatch), .output_enable(oen),
    .output_freq(ofreq), .current_limit(climit), .run_cancel(cancel),
    .state_code(state_code));
  motor_model motor_u (.clk_sys(clk_sys), .reset_n(reset_n), .output_enable(oen),
    .output_freq(ofreq), .current_limit(climit), .motor_freq(motor),
    .voltage_match(vmatch));

  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // bounded wait for a state, then one comparison on it
  task automatic wait_st(input logic [5:0] st, input int lim);
    int i;
    i = 0;
    while (state_code !== st && i < lim) begin
      @(negedge clk_sys);
      i++;
    end
    chk("state_code", 16'(state_code), 16'(st));
  endtask
  task automatic note(input logic [5:0] st, input logic en, input logic fchk,
                      input logic [15:0] fr, input logic [7:0] cl);
    notes.push_back('{st, en, fchk, fr, cl});
  endtask
  task automatic accel_to(input logic [15:0] from, input logic fchk, input logic [15:0] to);
    note(coast_pkg::S_ACCEL, 1'b1, fchk, from, FF);
    note(coast_pkg::S_RUN, 1'b1, 1'b1, to, FF);
  endtask
  task automatic coast_on();
    note(coast_pkg::S_COAST, 1'b0, 1'b0, 16'h0000, FF);
    term[ci] = 1'b1;
    wait_st(coast_pkg::S_COAST, 20);
  endtask
  // release into the retry wait; notes go first so no change can outrun them
  task automatic coast_off();
    note(coast_pkg::S_WAIT, 1'b0, 1'b0, 16'h0000, FF);
    term[ci] = 1'b0;
  endtask
  task automatic summarize();
    chk("pending notes", 16'(notes.size()), 16'h0000);
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // monitor: every state change against the oldest note
  // ****************************************
  // sampled at the falling edge so even a one-cycle state is seen settled
  always @(negedge clk_sys) begin
    if (reset_n && state_code !== last_st) begin
      last_st = state_code;
      n = (notes.size() != 0) ? notes.pop_front() : '0;
      checks_done++;
      if ({state_code, oen, n.fchk, n.fchk ? ofreq : n.fr, climit} !== n) begin
        $display("CHECK FAILED transition expected %h seen %h %h %h %h", n, state_code,
                 oen, ofreq, climit);
        n_mismatch++;
      end
    end
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    void'($urandom(21));
    ci = $urandom % 8;
    pi = (ci + 1 + $urandom % 3) % 8;
    ti = (ci + 4 + $urandom % 3) % 8;
    fsel[8*ci +: 8] = coast_pkg::FN_COAST_STOP;
    fsel[8*pi +: 8] = coast_pkg::FN_FORCE_PANEL;
    fsel[8*ti +: 8] = coast_pkg::FN_FORCE_TERM;
    retry = 10'h003 + 10'($urandom % 4);
    wc = int'(retry) * 20 + 1;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    chk("output_enable", 16'(oen), 16'h0000);
    chk("current_limit", 16'(climit), 16'h00ff);
    chk("run_cancel", 16'(cancel), 16'h0000);
    chk("output_freq", ofreq, 16'h0000);
    // zero restart ignores the retry wait
    accel_to(16'h0000, 1'b1, 16'h0008);
    run_c = 1'b1;
    wait_st(coast_pkg::S_RUN, 3000);
    coast_on();
    repeat (100) @(negedge clk_sys);
    chk("output_enable", 16'(oen), 16'h0000);
    accel_to(16'h0000, 1'b1, 16'h0008);
    term[ci] = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk("state_code", 16'(state_code), 16'(coast_pkg::S_ACCEL));
    wait_st(coast_pkg::S_RUN, 3000);
    $display("test zero restart done");
    // matched restart, coast stop returning in mid-wait
    mode = coast_pkg::MODE_MATCH;
    coast_on();
    coast_off();
    repeat (30) @(negedge clk_sys);
    coast_on();
    coast_off();
    repeat (wc - 10) @(negedge clk_sys);
    chk("state_code", 16'(state_code), 16'(coast_pkg::S_WAIT));
    accel_to(16'h0008, 1'b1, 16'h0008);
    wait_st(coast_pkg::S_RUN, 40);
    // below threshold, half base frequency, fast decay: all start at zero
    for (int k = 0; k < 3; k++) begin
      thr = (k == 0) ? 16'h0009 : 16'h0002;
      base = (k == 1) ? 16'h0010 : 16'h000a;
      decay = (k == 2);
      coast_on();
      coast_off();
      accel_to(16'h0000, 1'b1, 16'h0008);
      wait_st(coast_pkg::S_RUN, wc + 3000);
    end
    {thr, base, decay} = {16'h0002, 16'h000a, 1'b0};
    $display("test matched restart done");
    // active matching for each start select, random scan current for the first two, over-range 8'hc8 on the last
    mode = coast_pkg::MODE_ACTIVE;
    for (int k = 0; k < 3; k++) begin
      sel = 2'(k);
      scur = (k == 2) ? 8'hc8 : 8'($urandom);
      exp_cl = (scur < coast_pkg::SCAN_CUR_MIN) ? coast_pkg::SCAN_CUR_MIN :
        (scur > coast_pkg::SCAN_CUR_MAX) ? coast_pkg::SCAN_CUR_MAX : scur;
      start = (k == 0) ? 16'h0008 : (k == 1) ? fmax : 16'h000a;
      coast_on();
      if (k == 2) fcfg = 16'h000a;
      coast_off();
      note(coast_pkg::S_SCAN, 1'b1, 1'b1, start, exp_cl);
      note(coast_pkg::S_ACCEL, 1'b1, 1'b0, 16'h0000, FF);
      note(coast_pkg::S_RUN, 1'b1, 1'b1, 16'h0008, FF);
      wait_st(coast_pkg::S_SCAN, wc + 20);
      fcfg = 16'h0008;
      if (k == 1) begin
        repeat (1000) @(negedge clk_sys);
        chk("output_freq", ofreq, 16'h000c);
        repeat (1200) @(negedge clk_sys);
        chk("output_freq", ofreq, 16'h000b);
      end
      wait_st(coast_pkg::S_RUN, 12000);
    end
    $display("test active matching done");
    // panel as run source: release brings no restart
    note(coast_pkg::S_IDLE, 1'b0, 1'b0, 16'h0000, FF);
    run_c = 1'b0;
    wait_st(coast_pkg::S_IDLE, 10);
    rsrc = coast_pkg::SRC_PANEL;
    accel_to(16'h0000, 1'b1, 16'h0008);
    run_p = 1'b1;
    wait_st(coast_pkg::S_RUN, 3000);
    coast_on();
    note(coast_pkg::S_IDLE, 1'b0, 1'b0, 16'h0000, FF);
    term[ci] = 1'b0;
    wait_st(coast_pkg::S_IDLE, 20);
    run_p = 1'b0;
    rsrc = 2'h0;
    $display("test panel source done");
    // overrides switch the source and cancel a running command
    accel_to(16'h0000, 1'b1, 16'h0008);
    run_c = 1'b1;
    wait_st(coast_pkg::S_RUN, 3000);
    note(coast_pkg::S_IDLE, 1'b0, 1'b0, 16'h0000, FF);
    term[ti] = 1'b1;
    for (int i = 0; i < 20 && cancel !== 1'b1; i++) @(negedge clk_sys);
    chk("run_cancel", 16'(cancel), 16'h0001);
    run_c = 1'b0;
    repeat (20) @(negedge clk_sys);
    accel_to(16'h0000, 1'b1, 16'h0002);
    run_t = 1'b1;
    wait_st(coast_pkg::S_RUN, 1000);
    note(coast_pkg::S_IDLE, 1'b0, 1'b0, 16'h0000, FF);
    term[ti] = 1'b0;
    wait_st(coast_pkg::S_IDLE, 20);
    run_t = 1'b0;
    accel_to(16'h0000, 1'b1, 16'h0003);
    term[pi] = 1'b1;
    run_p = 1'b1;
    wait_st(coast_pkg::S_RUN, 1500);
    note(coast_pkg::S_IDLE, 1'b0, 1'b0, 16'h0000, FF);
    term[pi] = 1'b0;
    wait_st(coast_pkg::S_IDLE, 20);
    run_p = 1'b0;
    repeat (20) @(negedge clk_sys);
    $display("test source override done");
    summarize();
  end
endmodule
